// >>> logic/dcs_pkg.sv
// Overview of operation
// - command register write launches the selected operation
// - code 00 ends any running operation immediately
// - code 80 starts no disk activity
// - code 81 writes memory data into addressed sectors
// - code 82 finds matching ID, reads data to memory
// - byte after data mark checked, never sent to memory
// - sector end: zero count stops, else count and advance
// - stop during acknowledge halts at sector end, counters kept, except under code 86
// - count and sector number stay readable after halt
// - code 83 sends next ID and check bytes to memory
// - code 84 writes from index, IDs from registers
// - code 84 trails post-data on track end until index
// - code 85 writes sectors after the addressed sector
// - code 86 fetches ID bytes and filler from memory
// - code 87 formats one track index to index
// - code 87 ID bytes and filler come from registers
// - code 87 advances sector, track size; zero-fills end
// - code 87 never transfers to or from memory
// - code 88 reads from post-index gap without index
// - code 89 raises write gate at once, writes sectors
// - code 89 trails post-data on track end until index
// - code 8A writes zeroes until index or next command
// - errors never advance the sector number
// - stop input sets the transfer-stopped status bit
package dcs_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] OFS_DISK_STATUS = 7'h04;
  localparam logic [6:0] OFS_CTRL_STATUS = 7'h05;
  localparam logic [6:0] OFS_XFER_RD = 7'h06;
  localparam logic [6:0] OFS_SECTOR_RD = 7'h07;
  localparam logic [6:0] OFS_FILLER_SIZE = 7'h1A;
  localparam logic [6:0] OFS_TRACK_SIZE = 7'h1B;
  localparam logic [6:0] OFS_CYL_HIGH = 7'h38;
  localparam logic [6:0] OFS_CYL_LOW = 7'h39;
  localparam logic [6:0] OFS_HEAD = 7'h3A;
  localparam logic [6:0] OFS_SECTOR = 7'h3B;
  localparam logic [6:0] OFS_XFER = 7'h3C;
  localparam logic [6:0] OFS_COMMAND = 7'h3F;
  localparam logic [6:0] OFS_DISK_DATA = 7'h40;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_ABORT = 8'h00;
  localparam logic [7:0] CMD_NOP = 8'h80;
  localparam logic [7:0] CMD_WR_DATA = 8'h81;
  localparam logic [7:0] CMD_RD_DATA = 8'h82;
  localparam logic [7:0] CMD_HEADER_FETCH = 8'h83;
  localparam logic [7:0] CMD_WR_FIRST = 8'h84;
  localparam logic [7:0] CMD_WR_NEXT = 8'h85;
  localparam logic [7:0] CMD_FMT_INTLV = 8'h86;
  localparam logic [7:0] CMD_FMT_SEQ = 8'h87;
  localparam logic [7:0] CMD_RD_IMM = 8'h88;
  localparam logic [7:0] CMD_WR_IMM = 8'h89;
  localparam logic [7:0] CMD_GAP_IMM = 8'h8A;

  // ---------------------------------------------------------------
  // track fields and their lengths minus one, field 15 first
  // ---------------------------------------------------------------
  localparam logic [3:0] FLD_GAP = 4'h0;
  localparam logic [3:0] FLD_HEADER_MARK = 4'h3;
  localparam logic [3:0] FLD_ID_TAG = 4'h4;
  localparam logic [3:0] FLD_ID = 4'h5;
  localparam logic [3:0] FLD_ID_CHECK = 4'h6;
  localparam logic [3:0] FLD_SKEW = 4'h8;
  localparam logic [3:0] FLD_DATA_MARK = 4'hB;
  localparam logic [3:0] FLD_DATA_TAG = 4'hC;
  localparam logic [3:0] FLD_DATA = 4'hD;
  localparam logic [3:0] FLD_DATA_CHECK = 4'hE;
  localparam logic [3:0] FLD_POST = 4'hF;
  localparam logic [15:0][7:0] FIELD_LEN_M1 = {
    8'h0F, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h0B, 8'h00,
    8'h02, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h0B, 8'h0F};

  // mark bytes; the two mark values are plain defaults
  localparam logic [7:0] HEADER_MARK_BYTE = 8'hA1;
  localparam logic [7:0] DATA_MARK_BYTE = 8'hA1;
  localparam logic [7:0] ID_TAG_BYTE = 8'hFE;
  localparam logic [7:0] DATA_TAG_BYTE = 8'hF8;

  // ---------------------------------------------------------------
  // controller status bits and reset values
  // ---------------------------------------------------------------
  localparam int ST_NO_RECORD = 7;
  localparam int ST_MISS_MARK = 6;
  localparam int ST_ID_ERR = 5;
  localparam int ST_DATA_ERR = 4;
  localparam int ST_STOPPED = 2;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [19:0] PIN_RST = 20'hF0000;

  typedef enum logic [2:0] {
    DCS_IDLE = 3'b000,
    DCS_WAIT_IDX = 3'b001,
    DCS_RUN = 3'b010,
    DCS_TRAIL = 3'b011,
    DCS_GAP = 3'b100
  } dcs_state_t;

endpackage : dcs_pkg

// >>> logic/dcs_disk_command_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module dcs_disk_command_sequencer
  import dcs_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic csel_n,
  input wire logic wrt_n,
  input wire logic [6:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic dma_req_n,
  input wire logic dma_ack_n,
  input wire logic dma_stop_n,
  input wire logic index_pin,
  input wire logic ser_byte_stb,
  input wire logic [7:0] ser_rx_byte,
  input wire logic ser_check_err,
  output logic [7:0] ser_tx_byte,
  output logic write_gate,
  output logic read_gate,
  output logic busy
);

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [19:0] pin_m_r;
  logic [19:0] pin_s_r;
  logic hw_d_r;
  logic idx_d_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_m_r <= PIN_RST;
      pin_s_r <= PIN_RST;
      hw_d_r <= 1'b0;
      idx_d_r <= 1'b0;
    end else begin
      pin_m_r <= {csel_n, wrt_n, dma_ack_n, dma_stop_n, index_pin, addr, data_in};
      pin_s_r <= pin_m_r;
      hw_d_r <= ~pin_s_r[19] & ~pin_s_r[18];
      idx_d_r <= pin_s_r[15];
    end
  end

  logic host_sel;
  logic host_wr;
  logic ack;
  logic stop_in;
  logic idx;
  logic [6:0] a_s;
  logic [7:0] d_s;
  logic wr_evt;
  logic idx_evt;
  logic cmd_wr;

  assign host_sel = ~pin_s_r[19];
  assign host_wr = ~pin_s_r[18];
  assign ack = ~pin_s_r[17];
  assign stop_in = ~pin_s_r[16];
  assign idx = pin_s_r[15];
  assign a_s = pin_s_r[14:8];
  assign d_s = pin_s_r[7:0];
  assign wr_evt = host_sel & host_wr & ~hw_d_r;
  assign idx_evt = idx & ~idx_d_r;
  assign cmd_wr = wr_evt && (a_s == OFS_COMMAND);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] adv(input logic [11:0] p);
    if (p[7:0] == FIELD_LEN_M1[p[11:8]]) begin
      adv = {p[11:8] + 4'h1, 8'h00};
    end else begin
      adv = {p[11:8], p[7:0] + 8'h01};
    end
  endfunction : adv

  // memory bytes consumed while writing at position p
  function automatic logic mem_w(input logic [7:0] c, input logic [11:0] p);
    unique case (c)
      CMD_WR_DATA, CMD_WR_FIRST, CMD_WR_NEXT, CMD_WR_IMM: mem_w = (p[11:8] == FLD_DATA);
      CMD_FMT_INTLV: mem_w = (p[11:8] == FLD_ID) || ((p[11:8] == FLD_DATA) && (p[7:0] == 8'h00));
      default: mem_w = 1'b0;
    endcase
  endfunction : mem_w

  function automatic logic is_read(input logic [7:0] c);
    is_read = (c == CMD_RD_DATA) || (c == CMD_RD_IMM);
  endfunction : is_read

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dcs_state_t state_r;
  logic [7:0] cmd_r;
  logic [3:0] field_r;
  logic [7:0] bcnt_r;
  logic [7:0] cyl_hi_r;
  logic [7:0] cyl_lo_r;
  logic [7:0] head_r;
  logic [7:0] filler_size_r;
  logic [7:0] track_size_r;
  logic [7:0] sector_r;
  logic [7:0] xfer_r;
  logic [7:0] trk_r;
  logic [7:0] disk_data_r;
  logic [7:0] fill_r;
  logic cand_r;
  logic matched_r;
  logic found_r;
  logic [1:0] idx_cnt_r;
  logic stop_hit_r;
  logic [7:0] stat_r;
  logic wr_mode_r;
  logic dma_to_mem_r;
  logic dma_req_n_r;
  logic [7:0] tx_r;

  // ---------------------------------------------------------------
  // position arithmetic and byte generation
  // ---------------------------------------------------------------
  logic [11:0] pos;
  logic [11:0] np;
  logic [11:0] nnp;
  logic last_b;
  logic [7:0] id_exp;
  logic [7:0] tx_nxt;
  logic sec_end;

  always_comb begin
    pos = {field_r, bcnt_r};
    np = adv(pos);
    nnp = adv(np);
    last_b = (bcnt_r == FIELD_LEN_M1[field_r]);
    unique case (bcnt_r[1:0])
      2'd0: id_exp = cyl_hi_r;
      2'd1: id_exp = cyl_lo_r;
      2'd2: id_exp = head_r;
      default: id_exp = sector_r;
    endcase
    tx_nxt = 8'h00;
    unique case (np[11:8])
      FLD_HEADER_MARK: tx_nxt = HEADER_MARK_BYTE;
      FLD_ID_TAG: tx_nxt = ID_TAG_BYTE;
      FLD_DATA_MARK: tx_nxt = DATA_MARK_BYTE;
      FLD_DATA_TAG: tx_nxt = DATA_TAG_BYTE;
      FLD_ID: begin
        if (cmd_r == CMD_FMT_INTLV) begin
          tx_nxt = disk_data_r;
        end else begin
          unique case (np[1:0])
            2'd0: tx_nxt = cyl_hi_r;
            2'd1: tx_nxt = cyl_lo_r;
            2'd2: tx_nxt = head_r;
            default: tx_nxt = (cmd_r == CMD_FMT_SEQ) ? filler_size_r : sector_r;
          endcase
        end
      end
      FLD_DATA: begin
        if (cmd_r == CMD_FMT_SEQ) begin
          tx_nxt = disk_data_r;
        end else if (cmd_r == CMD_FMT_INTLV && np[7:0] != 8'h00) begin
          tx_nxt = fill_r;
        end else begin
          tx_nxt = disk_data_r;
        end
      end
      default: tx_nxt = 8'h00;
    endcase
    // a sector is complete at the last post-data byte of a written sector or of a matched sector under a read command
    sec_end = (state_r == DCS_RUN) && ser_byte_stb && (field_r == FLD_POST) && last_b &&
              (wr_mode_r || (matched_r && is_read(cmd_r)));
  end

  // ---------------------------------------------------------------
  // registers, command launch, field sequencing, dma
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= DCS_IDLE;
      cmd_r <= REG_RST;
      field_r <= FLD_GAP;
      bcnt_r <= REG_RST;
      cyl_hi_r <= REG_RST;
      cyl_lo_r <= REG_RST;
      head_r <= REG_RST;
      filler_size_r <= REG_RST;
      track_size_r <= REG_RST;
      sector_r <= REG_RST;
      xfer_r <= REG_RST;
      trk_r <= REG_RST;
      disk_data_r <= REG_RST;
      fill_r <= REG_RST;
      cand_r <= 1'b0;
      matched_r <= 1'b0;
      found_r <= 1'b0;
      idx_cnt_r <= 2'd0;
      stop_hit_r <= 1'b0;
      stat_r <= REG_RST;
      wr_mode_r <= 1'b0;
      dma_to_mem_r <= 1'b0;
      dma_req_n_r <= 1'b1;
      tx_r <= REG_RST;
    end else if (cmd_wr) begin
      // any command first ends what is running
      state_r <= DCS_IDLE;
      cmd_r <= d_s;
      dma_req_n_r <= 1'b1;
      wr_mode_r <= 1'b0;
      tx_r <= 8'h00;
      field_r <= FLD_GAP;
      bcnt_r <= 8'h00;
      cand_r <= 1'b0;
      matched_r <= 1'b0;
      found_r <= 1'b0;
      idx_cnt_r <= 2'd0;
      unique case (d_s)
        CMD_WR_DATA, CMD_RD_DATA, CMD_HEADER_FETCH, CMD_WR_NEXT, CMD_RD_IMM: begin
          state_r <= DCS_RUN;
          stat_r <= REG_RST;
          stop_hit_r <= 1'b0;
          trk_r <= track_size_r;
        end
        CMD_WR_FIRST, CMD_FMT_INTLV, CMD_FMT_SEQ: begin
          state_r <= DCS_WAIT_IDX;
          stat_r <= REG_RST;
          stop_hit_r <= 1'b0;
          trk_r <= track_size_r;
        end
        CMD_WR_IMM: begin
          state_r <= DCS_RUN;
          wr_mode_r <= 1'b1;
          stat_r <= REG_RST;
          stop_hit_r <= 1'b0;
          trk_r <= track_size_r;
        end
        CMD_GAP_IMM: begin
          state_r <= DCS_GAP;
          wr_mode_r <= 1'b1;
        end
        default: state_r <= DCS_IDLE;
      endcase
      // a stop that lands with the command write still shows: the set wins
      if (!dma_req_n_r && ack && stop_in) begin
        stat_r[ST_STOPPED] <= 1'b1;
      end
    end else begin
      // host register writes; count and sector stay as left after a halt
      if (wr_evt) begin
        unique case (a_s)
          OFS_CYL_HIGH: cyl_hi_r <= d_s;
          OFS_CYL_LOW: cyl_lo_r <= d_s;
          OFS_HEAD: head_r <= d_s;
          OFS_SECTOR: sector_r <= d_s;
          OFS_XFER: xfer_r <= d_s;
          OFS_FILLER_SIZE: filler_size_r <= d_s;
          OFS_TRACK_SIZE: track_size_r <= d_s;
          OFS_DISK_DATA: disk_data_r <= d_s;
          default: ;
        endcase
      end
      // dma handshake: a stop seen with acknowledge ends all further transfers
      if (!dma_req_n_r && ack) begin
        dma_req_n_r <= 1'b1;
        if (!dma_to_mem_r) begin
          disk_data_r <= d_s;
        end
        if (stop_in) begin
          stop_hit_r <= 1'b1;
          stat_r[ST_STOPPED] <= 1'b1;
        end
      end
      unique case (state_r)
        DCS_WAIT_IDX: begin
          if (idx_evt) begin
            state_r <= DCS_RUN;
            wr_mode_r <= 1'b1;
            tx_r <= 8'h00;
          end
        end
        DCS_GAP, DCS_TRAIL: begin
          tx_r <= 8'h00;
          if (idx_evt) begin
            state_r <= DCS_IDLE;
          end
        end
        DCS_RUN: begin
          if (idx_evt && (cmd_r == CMD_FMT_SEQ || cmd_r == CMD_FMT_INTLV)) begin
            state_r <= DCS_IDLE;
          end else if (idx_evt && !wr_mode_r) begin
            // two index pulses end a search; a miss sets no-record
            idx_cnt_r <= idx_cnt_r + 2'd1;
            if (idx_cnt_r != 2'd0) begin
              state_r <= DCS_IDLE;
              stat_r[ST_NO_RECORD] <= ~found_r;
            end
          end
          if (ser_byte_stb) begin
            field_r <= np[11:8];
            bcnt_r <= np[7:0];
            tx_r <= wr_mode_r ? tx_nxt : 8'h00;
            if (wr_mode_r && np[11:8] == FLD_DATA && np[7:0] == 8'h00) begin
              fill_r <= disk_data_r;
            end
            // memory bytes are fetched one byte slot ahead of use
            if (wr_mode_r && mem_w(cmd_r, nnp) && !stop_hit_r) begin
              dma_req_n_r <= 1'b0;
              dma_to_mem_r <= 1'b0;
            end
            if (!wr_mode_r) begin
              if (field_r == FLD_ID) begin
                cand_r <= (bcnt_r == 8'h00) ? (ser_rx_byte == id_exp) :
                          (cand_r && ser_rx_byte == id_exp);
              end
              if (cmd_r == CMD_HEADER_FETCH && (field_r == FLD_ID || field_r == FLD_ID_CHECK)
                  && !stop_hit_r) begin
                disk_data_r <= ser_rx_byte;
                dma_req_n_r <= 1'b0;
                dma_to_mem_r <= 1'b1;
              end
              if (field_r == FLD_ID_CHECK && last_b) begin
                if (cmd_r == CMD_HEADER_FETCH) begin
                  state_r <= DCS_IDLE;
                  stat_r[ST_ID_ERR] <= ser_check_err;
                end else if (cand_r && ser_check_err) begin
                  state_r <= DCS_IDLE;
                  stat_r[ST_ID_ERR] <= 1'b1;
                end else if (cand_r) begin
                  matched_r <= 1'b1;
                  found_r <= 1'b1;
                end
              end
              if (field_r == FLD_SKEW && last_b && matched_r && cmd_r == CMD_WR_DATA) begin
                wr_mode_r <= 1'b1;
              end
              if (matched_r && is_read(cmd_r)) begin
                if (field_r == FLD_DATA_TAG && ser_rx_byte != DATA_TAG_BYTE) begin
                  state_r <= DCS_IDLE;
                  stat_r[ST_MISS_MARK] <= 1'b1;
                end
                if (field_r == FLD_DATA && !stop_hit_r) begin
                  disk_data_r <= ser_rx_byte;
                  dma_req_n_r <= 1'b0;
                  dma_to_mem_r <= 1'b1;
                end
                if (field_r == FLD_DATA_CHECK && last_b && ser_check_err) begin
                  state_r <= DCS_IDLE;
                  stat_r[ST_DATA_ERR] <= 1'b1;
                end
              end
              if (field_r == FLD_POST && last_b && matched_r && cmd_r == CMD_WR_NEXT) begin
                wr_mode_r <= 1'b1;
                matched_r <= 1'b0;
                sector_r <= sector_r + 8'h01;
              end
            end
          end
          if (sec_end) begin
            matched_r <= 1'b0;
            if (cmd_r == CMD_WR_DATA) begin
              wr_mode_r <= 1'b0;
            end
            if (cmd_r == CMD_FMT_SEQ || cmd_r == CMD_FMT_INTLV) begin
              if (trk_r == 8'h00) begin
                state_r <= DCS_TRAIL;
              end else begin
                sector_r <= sector_r + 8'h01;
                trk_r <= trk_r - 8'h01;
              end
            end else if (stop_hit_r) begin
              state_r <= DCS_IDLE;
            end else if (xfer_r == 8'h00) begin
              state_r <= DCS_IDLE;
            end else if (trk_r == 8'h00 && (cmd_r == CMD_WR_FIRST || cmd_r == CMD_WR_IMM)) begin
              state_r <= DCS_TRAIL;
            end else begin
              xfer_r <= xfer_r - 8'h01;
              sector_r <= sector_r + 8'h01;
              trk_r <= trk_r - 8'h01;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // drive-side outputs, lagging the state by one cycle
  // ---------------------------------------------------------------
  logic write_gate_r;
  logic read_gate_r;
  logic busy_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      write_gate_r <= 1'b0;
      read_gate_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_r != DCS_IDLE);
      write_gate_r <= wr_mode_r && (state_r != DCS_IDLE) && (state_r != DCS_WAIT_IDX);
      read_gate_r <= !wr_mode_r && (state_r == DCS_RUN);
    end
  end

  // ---------------------------------------------------------------
  // host data bus: register reads and dma reads to memory
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] data_out_r;
  logic data_oe_r;

  always_comb begin
    unique case (a_s)
      OFS_DISK_STATUS: rd_mux = {2'b00, matched_r, (trk_r == 8'h00), field_r};
      OFS_CTRL_STATUS: rd_mux = stat_r;
      OFS_XFER_RD: rd_mux = xfer_r;
      OFS_SECTOR_RD: rd_mux = sector_r;
      OFS_DISK_DATA: rd_mux = disk_data_r;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_out_r <= REG_RST;
      data_oe_r <= 1'b0;
    end else begin
      data_oe_r <= (host_sel || (ack && dma_to_mem_r)) && !host_wr;
      data_out_r <= (ack && dma_to_mem_r) ? disk_data_r : rd_mux;
    end
  end

  assign data_out = data_out_r;
  assign data_oe = data_oe_r;
  assign dma_req_n = dma_req_n_r;
  assign ser_tx_byte = tx_r;
  assign write_gate = write_gate_r;
  assign read_gate = read_gate_r;
  assign busy = busy_r;

endmodule : dcs_disk_command_sequencer
`default_nettype wire

// >>> sim/dcs_disk_command_sequencer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module dcs_checker
  import dcs_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic csel_n,
  input wire logic wrt_n,
  input wire logic [6:0] addr,
  input wire logic [7:0] data_in,
  input wire logic dma_req_n,
  input wire logic dma_ack_n,
  input wire logic busy,
  input wire logic write_gate,
  input wire logic read_gate
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // seen at the pins; the synchronisers delay the take by three edges
  sequence s_cmd(logic [7:0] c);
    $fell(wrt_n) && !csel_n && addr == OFS_COMMAND && data_in == c;
  endsequence
  sequence s_quiet;
    !busy ##1 !busy;
  endsequence
  property p_abort; s_cmd(CMD_ABORT) |-> ##[2:10] !busy; endproperty
  a_abort: assert property (p_abort) else $error("abort left busy");
  property p_nop; s_cmd(CMD_NOP) ##0 !busy |-> ##1 !busy [*8]; endproperty
  a_nop: assert property (p_nop) else $error("no-op started work");
  property p_undef; s_cmd(8'h9F) ##0 !busy |-> ##1 !busy [*8]; endproperty
  a_undef: assert property (p_undef) else $error("unknown code ran");
  property p_gap; s_cmd(CMD_GAP_IMM) |-> ##[2:8] busy && write_gate; endproperty
  a_gap: assert property (p_gap) else $error("gap write late");
  property p_wimm; s_cmd(CMD_WR_IMM) |-> ##[2:8] write_gate; endproperty
  a_wimm: assert property (p_wimm) else $error("write gate late");
  property p_rimm; s_cmd(CMD_RD_IMM) |-> ##[2:8] read_gate && !write_gate; endproperty
  a_rimm: assert property (p_rimm) else $error("read gate late");
  property p_ack; !dma_req_n && $fell(dma_ack_n) |-> ##[1:5] dma_req_n; endproperty
  a_ack: assert property (p_ack) else $error("request held after ack");
  property p_idle; s_quiet |-> !write_gate && !read_gate && dma_req_n; endproperty
  a_idle: assert property (p_idle) else $error("activity while idle");
endmodule : dcs_checker
bind dcs_disk_command_sequencer dcs_checker dcs_checker_inst (
  .mclk(mclk), .arst_n(arst_n), .csel_n(csel_n), .wrt_n(wrt_n), .addr(addr),
  .data_in(data_in), .dma_req_n(dma_req_n), .dma_ack_n(dma_ack_n), .busy(busy),
  .write_gate(write_gate), .read_gate(read_gate));
`default_nettype wire

// >>> sim/dcs_partner.sv
`timescale 1ns/100ps
`default_nettype none
module dcs_partner
  import dcs_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic restart,
  input wire logic [9:0] stop_at,
  input wire logic dma_req_n,
  output logic dma_ack_n,
  output logic dma_stop_n,
  output logic ser_byte_stb,
  output logic [7:0] ser_rx_byte,
  output logic [9:0] n_bytes
);
  logic [2:0] tick_r;
  logic [3:0] fld_r;
  logic [7:0] pos_r, sec_r;
  logic fld_end;
  assign ser_byte_stb = tick_r == 3'h7;
  assign fld_end = pos_r == FIELD_LEN_M1[fld_r];
  // track image from the post-index gap; ids 00 00 00 and sector from 05
  always_comb begin
    case (fld_r)
      FLD_HEADER_MARK: ser_rx_byte = HEADER_MARK_BYTE;
      FLD_DATA_MARK: ser_rx_byte = DATA_MARK_BYTE;
      FLD_ID_TAG: ser_rx_byte = ID_TAG_BYTE;
      FLD_DATA_TAG: ser_rx_byte = DATA_TAG_BYTE;
      FLD_ID: ser_rx_byte = (pos_r == 8'h03) ? sec_r : 8'h00;
      FLD_DATA: ser_rx_byte = pos_r ^ 8'h5A;
      default: ser_rx_byte = 8'h00;
    endcase
  end
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n || restart) begin
      {tick_r, fld_r, pos_r, sec_r} <= {3'h0, FLD_GAP, 8'h00, 8'h05};
      {dma_ack_n, dma_stop_n, n_bytes} <= {2'b11, 10'h000};
    end else begin
      tick_r <= tick_r + 3'h1;
      if (ser_byte_stb) begin
        pos_r <= fld_end ? 8'h00 : pos_r + 8'h01;
        fld_r <= fld_r + {3'h0, fld_end};
        sec_r <= sec_r + {7'h00, fld_end && fld_r == FLD_POST};
      end
      if (dma_ack_n) begin
        dma_ack_n <= dma_req_n;
        // stop only ever shows while acknowledge is low
        dma_stop_n <= dma_req_n || n_bytes != stop_at;
      end else if (dma_req_n) begin
        {dma_ack_n, dma_stop_n} <= 2'b11;
        n_bytes <= n_bytes + 10'h001;
      end
    end
  end
endmodule : dcs_partner
`default_nettype wire

// >>> sim/dcs_disk_command_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
module dcs_disk_command_sequencer_test
  import dcs_pkg::*;
;
  logic mclk, arst_n, csel_n, wrt_n, index_pin, restart, busy, write_gate;
  logic read_gate, dma_req_n, dma_ack_n, dma_stop_n, stb, oe, ck_err;
  logic [6:0] addr;
  logic [7:0] data_in, data_out, rx, tx;
  logic [9:0] stop_at, n_bytes;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  dcs_disk_command_sequencer dcs_disk_command_sequencer_inst (
    .mclk(mclk), .arst_n(arst_n), .csel_n(csel_n), .wrt_n(wrt_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(oe), .dma_req_n(dma_req_n),
    .dma_ack_n(dma_ack_n), .dma_stop_n(dma_stop_n), .index_pin(index_pin),
    .ser_byte_stb(stb), .ser_rx_byte(rx), .ser_check_err(ck_err), .ser_tx_byte(tx),
    .write_gate(write_gate), .read_gate(read_gate), .busy(busy));
  dcs_partner dcs_partner_inst (
    .mclk(mclk), .arst_n(arst_n), .restart(restart), .stop_at(stop_at),
    .dma_req_n(dma_req_n), .dma_ack_n(dma_ack_n), .dma_stop_n(dma_stop_n),
    .ser_byte_stb(stb), .ser_rx_byte(rx), .n_bytes(n_bytes));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end
  // a byte to memory is seen once, at the edge after the request has dropped
  always @(posedge mclk) begin
    if (!dma_ack_n && dma_req_n && oe) begin
      chk(data_out, {2'b00, n_bytes[7:0] ^ 8'h5A});
    end
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // strobes held four edges to cover the three-edge sync, then three idle
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    {csel_n, wrt_n, addr, data_in, restart} <= {1'b0, !w, a, d, w && a == OFS_COMMAND};
    repeat (4) @(posedge mclk);
    if (!w)
      chk({oe, data_out}, {1'b1, d});
    {csel_n, wrt_n, restart} <= 3'b110;
    repeat (3) @(posedge mclk);
  endtask : acc
  task automatic idle(input int lim);
    for (int i = 0; i < lim && busy !== 1'b0; i++)
      @(posedge mclk);
    chk(busy, 1'b0);
  endtask : idle
  task automatic pulse();
    index_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    index_pin <= 1'b0;
  endtask : pulse
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  initial begin
    {arst_n, csel_n, wrt_n, index_pin, restart, ck_err} = 6'b011000;
    {addr, data_in, stop_at} = {7'h00, 8'h00, 10'h3FF};
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    acc(1'b0, 7'h02, 8'h00);
    acc(1'b1, OFS_COMMAND, CMD_NOP);
    chk(busy, 1'b0);
    acc(1'b1, OFS_COMMAND, 8'h9F);
    chk(busy, 1'b0);
    acc(1'b1, OFS_COMMAND, CMD_GAP_IMM);
    chk({busy, write_gate, tx}, 10'h300);
    pulse();
    idle(20);
    acc(1'b1, OFS_COMMAND, CMD_WR_IMM);
    chk({busy, write_gate}, 10'h003);
    acc(1'b1, OFS_COMMAND, CMD_ABORT);
    chk(busy, 1'b0);
    // two sectors per track: the first advances the sector, the last trails zeroes
    acc(1'b1, OFS_TRACK_SIZE, 8'h01);
    acc(1'b1, OFS_COMMAND, CMD_FMT_SEQ);
    pulse();
    repeat (5600) @(posedge mclk);
    chk(dma_req_n, 1'b1);
    chk(n_bytes, 10'h000);
    chk({busy, write_gate, tx}, 10'h300);
    pulse();
    idle(20);
    acc(1'b0, OFS_SECTOR_RD, 8'h01);
    // second pass stops the transfer on the tenth byte, third meets a bad id check
    for (int i = 0; i < 3; i++) begin
      stop_at <= (i == 1) ? 10'h009 : 10'h3FF;
      ck_err <= (i == 2);
      acc(1'b1, OFS_SECTOR, 8'h05);
      acc(1'b1, OFS_XFER, 8'h01);
      acc(1'b1, OFS_COMMAND, CMD_RD_IMM);
      chk(read_gate, 1'b1);
      idle(8000);
      chk(n_bytes, (i == 0) ? 10'h200 : (i == 1) ? 10'h00A : 10'h000);
      acc(1'b0, OFS_XFER_RD, i ? 8'h01 : 8'h00);
      acc(1'b0, OFS_SECTOR_RD, i ? 8'h05 : 8'h06);
      acc(1'b0, OFS_CTRL_STATUS, (i == 0) ? 8'h00 : (i == 1) ? 8'h04 : 8'h20);
    end
    conclude();
  end
endmodule : dcs_disk_command_sequencer_test
`default_nettype wire
